// ### bench/ofbid_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the strobe port; every request moves just after a clock edge.
module ofbid_host (
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   output var  logic [4:0]  addr_o,
   output var  logic        wr_o,
   output var  logic        rd_o,
   output var  logic [15:0] wdata_o
);
   // Idle bus at time zero.
   initial begin
      {addr_o, wr_o, rd_o, wdata_o} = '0;
   end
   // Write strobe is held over exactly one taking edge.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i) {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
      @(posedge clk_i) wr_o <= 1'b0;
      #1;
   endtask
   // Read data stands just after the taking edge and is sampled 1 ns later.
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_i) {addr_o, rd_o} <= {a, 1'b1};
      @(posedge clk_i) rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule
`default_nettype wire

// ### bench/ofbid_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ofbid_sva (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        freeze_request_pin_i,
   input wire logic [3:0]  identifier_switch_i,
   input wire logic [4:0]  addr_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] wdata_i,
   input wire logic [15:0] rdata_o,
   input wire logic        rvalid_o,
   input wire logic [63:0] isolated_output_o,
   input wire logic        freeze_active_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_reset_open: assert property ($rose(resetn_i) |-> isolated_output_o == 64'h0)
      else $error("outputs not open after reset");
   a_write_lands: assert property (wr_i && addr_i == 5'h00 && !freeze_active_flag_o
      |=> isolated_output_o[15:0] == $past(wdata_i)) else $error("group write lost");
   a_frozen_hold: assert property (freeze_active_flag_o |=> $stable(isolated_output_o))
      else $error("output moved during freeze");
   a_pin_freeze: assert property (freeze_request_pin_i [*3] |=> freeze_active_flag_o)
      else $error("pin did not freeze");
   a_soft_freeze: assert property (wr_i && addr_i == 5'h12 && wdata_i[0] |-> ##2 freeze_active_flag_o)
      else $error("control bit did not freeze");
   a_rvalid_after: assert property (rd_i |=> rvalid_o)
      else $error("no read answer");
   a_status_read: assert property (rvalid_o && $past(addr_i) == 5'h12
      |-> rdata_o[1] == $past(freeze_active_flag_o)) else $error("status bit wrong");
   a_id_read: assert property (rvalid_o && $past(addr_i) == 5'h10 && $past(identifier_switch_i, 4) == identifier_switch_i
      |-> rdata_o[3:0] == ~identifier_switch_i) else $error("identifier wrong");
   c_pin: cover property (freeze_request_pin_i [*3] ##1 freeze_active_flag_o);
   c_soft: cover property (wr_i && addr_i == 5'h12 && wdata_i[0]);
   c_drop: cover property (wr_i && freeze_active_flag_o);
endmodule
bind ofbid_output_freeze_board_id ofbid_sva i_ofbid_sva (.*);
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        pin = 1'b0;
   logic [3:0]  sw = 4'hF;
   logic [4:0]  addr;
   logic        wr, rd, flag, rvalid;
   logic        hot = 1'b0;
   logic        jmp = 1'b0;
   logic [15:0] wdata, rdata, d;
   logic [63:0] outs;
   int          bad_count = 0;
   int          checked = 0;
   // Clock of 100 ns period.
   always #50 clk_i = ~clk_i;
   ofbid_output_freeze_board_id i_ofbid_output_freeze_board_id (.clk_i(clk_i), .resetn_i(resetn_i),
      .hot_reset_i(hot), .hot_reset_jumper_i(jmp), .freeze_request_pin_i(pin),
      .identifier_switch_i(sw), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
      .rdata_o(rdata), .rvalid_o(rvalid), .isolated_output_o(outs), .freeze_active_flag_o(flag));
   ofbid_host i_ofbid_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata));
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Bounded wait for the freeze flag to reach a level.
   task automatic wait_flag(input logic v);
      for (int i = 0; i < 20 && flag !== v; i++) @(negedge clk_i);
      chk(flag, v);
   endtask
   task automatic t_id();
      // Let the switch synchroniser fill before the first identifier read.
      repeat (4) @(posedge clk_i);
      i_ofbid_host.rd(5'h10, d);
      chk(rvalid, 64'h1);
      chk(d, 64'h0);
      @(posedge clk_i) sw <= 4'hA;
      repeat (4) @(posedge clk_i);
      i_ofbid_host.rd(5'h10, d);
      chk(d, 64'h5);
   endtask
   task automatic t_soft();
      chk(outs, 64'h0);
      for (int g = 0; g < 4; g++) i_ofbid_host.wr(5'(2 * g), 16'hA5A0 + 16'(g));
      chk(outs, 64'hA5A3_A5A2_A5A1_A5A0);
      i_ofbid_host.wr(5'h12, 16'h0001);
      wait_flag(1'b1);
      i_ofbid_host.rd(5'h12, d);
      chk(d, 64'h3);
      i_ofbid_host.wr(5'h00, 16'h1234);
      i_ofbid_host.wr(5'h12, 16'h0000);
      wait_flag(1'b0);
      chk(outs, 64'hA5A3_A5A2_A5A1_A5A0);
   endtask
   task automatic t_pin();
      @(posedge clk_i) pin <= 1'b1;
      wait_flag(1'b1);
      i_ofbid_host.wr(5'h06, 16'h0F0F);
      chk(outs[63:48], 64'hA5A3);
      @(posedge clk_i) pin <= 1'b0;
      wait_flag(1'b0);
   endtask
   // Hot reset keeps outputs with the jumper high and opens them with it low.
   task automatic t_hot();
      @(posedge clk_i) {hot, jmp} <= 2'b11;
      @(posedge clk_i) hot <= 1'b0;
      #1 chk(outs, 64'hA5A3_A5A2_A5A1_A5A0);
      @(posedge clk_i) {hot, jmp} <= 2'b10;
      @(posedge clk_i) hot <= 1'b0;
      #1 chk(outs, 64'h0);
   endtask
   task automatic conclude();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_id();
      t_soft();
      t_pin();
      t_hot();
      conclude();
   end
endmodule
`default_nettype wire

// ### shared/ofbid_freeze_if.sv
`timescale 1ns/1ps
`default_nettype none
// Freeze request and state between the register block and freeze logic.
interface ofbid_freeze_if;
   logic pin_sync;
   logic soft_en;
   logic active;
   modport ctrl  (output pin_sync, output soft_en, input active);
   modport gate  (input pin_sync, input soft_en, output active);
endinterface
`default_nettype wire

// ### shared/ofbid_pkg.sv
package ofbid_pkg;

   // ****************************************************************
   // Register map (byte offsets in the card's I/O window)
   // ****************************************************************
   localparam logic [4:0] ADDR_GROUP0    = 5'h00;
   localparam logic [4:0] ADDR_GROUP1    = 5'h02;
   localparam logic [4:0] ADDR_GROUP2    = 5'h04;
   localparam logic [4:0] ADDR_GROUP3    = 5'h06;
   localparam logic [4:0] ADDR_BOARD_ID  = 5'h10;
   localparam logic [4:0] ADDR_FREEZE    = 5'h12;

   // ****************************************************************
   // Field layout and sizes
   // ****************************************************************
   localparam int         GROUP_WIDTH    = 16;
   localparam int         GROUP_COUNT    = 4;
   localparam int         CHANNEL_COUNT  = 64;
   localparam int         ID_WIDTH       = 4;
   localparam int         FRZ_EN_POS     = 0;
   localparam int         FRZ_ON_POS     = 1;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [63:0] OUTPUT_OPEN   = 64'h0000_0000_0000_0000;
   localparam logic [15:0] READ_ZERO     = 16'h0000;

   // Sequencing of the hot reset restore.
   typedef enum logic [1:0] {
      OFBID_RUN,
      OFBID_HOT_RESET
   } ofbid_mode_t;

endpackage

// ### src/ofbid_freeze_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Combines pin and software requests into one registered freeze state.
module ofbid_freeze_gate (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   ofbid_freeze_if.gate     frz
);
   typedef struct packed {
      logic active;
   } ofbid_gate_state_t;

   ofbid_gate_state_t st;
   ofbid_gate_state_t next_st;

   // Either source raises freeze.
   always_comb begin
      next_st        = st;
      next_st.active = frz.pin_sync | frz.soft_en;
   end

   // State register.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign frz.active = st.active;
endmodule
`default_nettype wire

// ### src/ofbid_output_freeze_board_id.sv
// Contract
// - Sixty-four output channels follow host-written data while freeze is off.
// - Four-bit board identifier readable, bit 0 least significant, bit 3 most.
// - Identifier bit reads 1 for switch off, 0 for on.
// - Factory switch setting (all on) reads identifier 0.
// - During freeze host writes never reach the output ports.
// - Entering freeze, each port holds its last valid value.
// - Asserted freeze pin activates freeze.
// - Writing 1 to the software control bit activates freeze like the pin.
// - Status flag reads 1 while freeze active, 0 otherwise.
// - Freeze register bit 0 is control, bit 1 is status.
// - Outputs form four groups of sixteen channels.
// - Power-on or hardware reset opens every output channel.
// - Hot reset keeps outputs or loads defaults, chosen by jumper.
`timescale 1ns/1ps
`default_nettype none
module ofbid_output_freeze_board_id (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        hot_reset_i,
   input  wire logic        hot_reset_jumper_i,
   input  wire logic        freeze_request_pin_i,
   input  wire logic [3:0]  identifier_switch_i,
   input  wire logic [4:0]  addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [15:0] wdata_i,
   output var  logic [15:0] rdata_o,
   output var  logic        rvalid_o,
   output var  logic [63:0] isolated_output_o,
   output var  logic        freeze_active_flag_o
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0]  pin_meta;
      logic [3:0]  sw_meta;
      logic [3:0]  sw_sync;
      logic        freeze_enable_bit;
      logic [63:0] outputs;
      logic [15:0] rdata;
      logic        rvalid;
   } ofbid_state_t;

   ofbid_state_t st;
   ofbid_state_t next_st;
   ofbid_freeze_if frz ();

   // Read decode for every mapped address, zero elsewhere.
   function automatic logic [15:0] ofbid_read(input logic [4:0] a, input ofbid_state_t s,
                                              input logic act);
      logic [15:0] r;
      r = ofbid_pkg::READ_ZERO;
      unique case (a)
         ofbid_pkg::ADDR_GROUP0:   r = s.outputs[15:0];
         ofbid_pkg::ADDR_GROUP1:   r = s.outputs[31:16];
         ofbid_pkg::ADDR_GROUP2:   r = s.outputs[47:32];
         ofbid_pkg::ADDR_GROUP3:   r = s.outputs[63:48];
         ofbid_pkg::ADDR_BOARD_ID: r = {12'h000, ~s.sw_sync};
         ofbid_pkg::ADDR_FREEZE: begin
            r[ofbid_pkg::FRZ_EN_POS] = s.freeze_enable_bit;
            r[ofbid_pkg::FRZ_ON_POS] = act;
         end
         default:                  r = ofbid_pkg::READ_ZERO;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Freeze combine
   // ****************************************************************
   assign frz.pin_sync = st.pin_meta[1];
   assign frz.soft_en  = st.freeze_enable_bit;

   ofbid_freeze_gate u_gate (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .frz      (frz)
   );

   // Next-state logic: synchronisers, register writes, reads.
   always_comb begin
      next_st          = st;
      next_st.pin_meta = {st.pin_meta[0], freeze_request_pin_i};
      next_st.sw_meta  = identifier_switch_i;
      next_st.sw_sync  = st.sw_meta;
      next_st.rvalid   = rd_i;
      next_st.rdata    = rd_i ? ofbid_read(addr_i, st, frz.active) : ofbid_pkg::READ_ZERO;
      if (wr_i && addr_i == ofbid_pkg::ADDR_FREEZE) begin
         next_st.freeze_enable_bit = wdata_i[ofbid_pkg::FRZ_EN_POS];
      end
      // Group writes pass only while freeze is off; frozen writes are lost.
      if (wr_i && !frz.active) begin
         for (int g = 0; g < ofbid_pkg::GROUP_COUNT; g++) begin
            if (addr_i == 5'(2 * g)) begin
               next_st.outputs[g*16 +: 16] = wdata_i;
            end
         end
      end
      // Hot reset with jumper low restores the open state.
      if (hot_reset_i && !hot_reset_jumper_i) begin
         next_st.outputs           = ofbid_pkg::OUTPUT_OPEN;
         next_st.freeze_enable_bit = 1'b0;
      end
   end

   // State register; hard reset opens all outputs.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdata_o              = st.rdata;
   assign rvalid_o             = st.rvalid;
   assign isolated_output_o    = st.outputs;
   assign freeze_active_flag_o = frz.active;
endmodule
`default_nettype wire
